//--- dasp_asserts.sv
// Concurrent checks on the ports of the dual serial port top
`timescale 1ns/1ps
`default_nettype none
module dasp_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic app_start_i,
    input wire logic port_zero_transmit_line_o,
    input wire logic port_one_transmit_line_o,
    input wire logic [1:0] tx_valid_i,
    input wire logic [1:0] tx_ready_o,
    input wire logic [1:0] rx_valid_o,
    input wire logic port_zero_app_o,
    input wire logic [1:0] frame_err_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Helper: saturating count of cycles the reset pin is low
    logic [6:0] low_cnt_ff;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_ff <= 7'h00;
        end else if (master_reset_n_i) begin
            low_cnt_ff <= 7'h00;
        end else if (low_cnt_ff != 7'h7f) begin
            low_cnt_ff <= low_cnt_ff + 7'h01;
        end
    end
    // ==========================================================
    // Transmit framing
    sequence s_take0;
        tx_valid_i[0] && tx_ready_o[0];
    endsequence
    sequence s_start0;
        !port_zero_transmit_line_o;
    endsequence
    sequence s_short_bit1;
        (!port_one_transmit_line_o) [*8];
    endsequence
    AST_TX0_START: assert property (s_take0 |-> ##2 s_start0)
        else $error("port zero start bit not on time");
    AST_TX1_BIT_WIDTH: assert property ($fell(port_one_transmit_line_o) |-> s_short_bit1)
        else $error("port one low bit too short");
    AST_TX0_IDLE: assert property (tx_ready_o[0] && $past(tx_ready_o[0]) |-> port_zero_transmit_line_o)
        else $error("port zero line low while idle");
    AST_TX1_STOP: assert property ($rose(tx_ready_o[1]) |-> port_one_transmit_line_o && $past(port_one_transmit_line_o))
        else $error("port one frame ended without stop level");
    // ==========================================================
    // Port zero ownership, master reset and port one frame error pulse
    AST_LOADER_TX: assert property (!port_zero_app_o && !$past(port_zero_app_o) |-> !tx_ready_o[0])
        else $error("port zero transmit offered in loader mode");
    AST_LOADER_RX: assert property (!port_zero_app_o |-> !rx_valid_o[0])
        else $error("port zero byte reached application in loader mode");
    AST_APP_SET: assert property (app_start_i && master_reset_n_i |-> ##[1:2] port_zero_app_o)
        else $error("port zero not handed to application");
    AST_APP_STICKY: assert property (port_zero_app_o && master_reset_n_i |=> port_zero_app_o)
        else $error("application ownership lost");
    AST_SHORT_LOW: assert property (!master_reset_n_i && low_cnt_ff < 7'h28 && port_zero_app_o |=> port_zero_app_o)
        else $error("short reset pulse cleared the block");
    AST_LONG_LOW: assert property (low_cnt_ff > 7'h38 |-> !port_zero_app_o && port_zero_transmit_line_o && port_one_transmit_line_o && tx_ready_o == 2'b00)
        else $error("long reset pulse did not clear the block");
    AST_FERR_PULSE: assert property ($rose(frame_err_o[1]) |=> !frame_err_o[1])
        else $error("frame error flag longer than one cycle");
endmodule
bind dasp_top dasp_asserts u_asserts (
    .clk_sys_i,
    .rst_i,
    .master_reset_n_i,
    .app_start_i,
    .port_zero_transmit_line_o,
    .port_one_transmit_line_o,
    .tx_valid_i,
    .tx_ready_o,
    .rx_valid_o,
    .port_zero_app_o,
    .frame_err_o
);
`default_nettype wire

//--- dasp_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dasp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic flush_i,
    dasp_stream_if.snk wr,
    output logic rd_valid_o,
    output logic [WIDTH-1:0] rd_data_o,
    input wire logic rd_ready_i,
    output logic full_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic push;
    logic pop;
    logic empty;

    assign empty = (wp_ff == rp_ff);
    assign full_o = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    // Back-pressure: the engine sees ready low once full
    assign wr.ready = ~full_o;
    assign push = wr.valid & ~full_o;
    assign pop = rd_ready_i & ~empty;
    assign rd_valid_o = ~empty;
    assign rd_data_o = mem_ff[rp_ff[AW-1:0]];

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (flush_i) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + (AW+1)'(1);
            end
            if (pop) begin
                rp_ff <= rp_ff + (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

//--- dasp_pkg.sv
// Package of constants and types for the dual asynchronous serial ports
package dasp_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 25000000;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 600000;
    localparam int DIV_W = 17;
    // Cycles per bit at the lowest and highest rates
    localparam int DIV_MAX = CLK_HZ / BAUD_MIN;
    localparam int DIV_MIN = CLK_HZ / BAUD_MAX;
    localparam logic [DIV_W-1:0] DIV_RST = 17'(CLK_HZ / 115200);
    // Reset pin low time, in ns, and the cycles it covers (rounded up)
    localparam int RST_MIN_NS = 2000;
    localparam int CLK_NS = 40;
    localparam int RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] RST_CYC_W = 7'(RST_CYC);
    // ==========================================================
    // Frame format
    localparam int DATA_BITS = 8;
    localparam logic START_LVL = 1'b0;
    localparam logic STOP_LVL = 1'b1;
    localparam logic IDLE_LVL = 1'b1;
    localparam int FIFO_DEPTH = 32;
    // ==========================================================
    // Port 0 ownership
    typedef enum logic [0:0] {
        DASP_OWN_LOADER = 1'b0,
        DASP_OWN_APP = 1'b1
    } dasp_own_e;
endpackage

//--- dasp_port.sv
// One full-duplex serial port: transmitter and receiver engines
`timescale 1ns/1ps
`default_nettype none
module dasp_port (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [16:0] div_i,
    input wire logic rx_line_i,
    output logic tx_line_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic frame_err_o,
    output logic overrun_o,
    dasp_stream_if.src rx
);
    // ==========================================================
    // Transmitter
    typedef enum logic [1:0] {
        DASP_TX_IDLE = 2'b00,
        DASP_TX_START = 2'b01,
        DASP_TX_DATA = 2'b11,
        DASP_TX_STOP = 2'b10
    } dasp_tx_e;
    dasp_tx_e tx_st_ff;
    logic [16:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic tx_tick;

    assign tx_tick = (tx_cnt_ff == 17'h00000);
    assign tx_ready_o = (tx_st_ff == DASP_TX_IDLE);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_ff <= DASP_TX_IDLE;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff <= '0;
            tx_line_o <= dasp_pkg::IDLE_LVL;
        end else begin
            tx_cnt_ff <= tx_tick ? div_i - 17'h00001 : tx_cnt_ff - 17'h00001;
            case (tx_st_ff)
                DASP_TX_IDLE: begin
                    tx_line_o <= dasp_pkg::IDLE_LVL;
                    if (tx_valid_i) begin
                        tx_sh_ff <= tx_data_i;
                        tx_cnt_ff <= div_i - 17'h00001;
                        tx_line_o <= dasp_pkg::START_LVL;
                        tx_st_ff <= DASP_TX_START;
                    end
                end
                DASP_TX_START: begin
                    if (tx_tick) begin
                        tx_line_o <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                        tx_bit_ff <= '0;
                        tx_st_ff <= DASP_TX_DATA;
                    end
                end
                DASP_TX_DATA: begin
                    if (tx_tick) begin
                        if (tx_bit_ff == 3'h7) begin
                            tx_line_o <= dasp_pkg::STOP_LVL;
                            tx_st_ff <= DASP_TX_STOP;
                        end else begin
                            tx_line_o <= tx_sh_ff[0];
                            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                            tx_bit_ff <= tx_bit_ff + 3'h1;
                        end
                    end
                end
                DASP_TX_STOP: begin
                    // One stop bit only
                    if (tx_tick) begin
                        tx_st_ff <= DASP_TX_IDLE;
                    end
                end
                default: begin
                    tx_st_ff <= DASP_TX_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Receiver; samples at mid bit, so no oversampling clock is needed
    typedef enum logic [1:0] {
        DASP_RX_IDLE = 2'b00,
        DASP_RX_START = 2'b01,
        DASP_RX_DATA = 2'b11,
        DASP_RX_STOP = 2'b10
    } dasp_rx_e;
    dasp_rx_e rx_st_ff;
    logic [16:0] rx_cnt_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic rx_q1_ff;
    logic rx_q2_ff;
    logic rx_tick;

    assign rx_tick = (rx_cnt_ff == 17'h00000);

    // Extra resample stage guards against a slow edge on the pin
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_q1_ff <= 1'b1;
            rx_q2_ff <= 1'b1;
        end else begin
            rx_q1_ff <= rx_line_i;
            rx_q2_ff <= rx_q1_ff;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_ff <= DASP_RX_IDLE;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            rx.valid <= 1'b0;
            rx.data <= '0;
            frame_err_o <= 1'b0;
            overrun_o <= 1'b0;
        end else begin
            frame_err_o <= 1'b0;
            overrun_o <= 1'b0;
            rx.valid <= 1'b0;
            rx_cnt_ff <= rx_tick ? div_i - 17'h00001 : rx_cnt_ff - 17'h00001;
            case (rx_st_ff)
                DASP_RX_IDLE: begin
                    if (rx_q2_ff == dasp_pkg::START_LVL) begin
                        rx_cnt_ff <= {1'b0, div_i[16:1]};
                        rx_st_ff <= DASP_RX_START;
                    end
                end
                DASP_RX_START: begin
                    if (rx_tick) begin
                        // Glitch shorter than half a bit is not a start bit
                        rx_st_ff <= (rx_q2_ff == dasp_pkg::START_LVL) ?
                            DASP_RX_DATA : DASP_RX_IDLE;
                        rx_bit_ff <= '0;
                    end
                end
                DASP_RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh_ff <= {rx_q2_ff, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'h7) begin
                            rx_st_ff <= DASP_RX_STOP;
                        end
                    end
                end
                DASP_RX_STOP: begin
                    if (rx_tick) begin
                        rx_st_ff <= DASP_RX_IDLE;
                        if (rx_q2_ff == dasp_pkg::STOP_LVL) begin
                            // Store without software help
                            rx.valid <= rx.ready;
                            rx.data <= rx_sh_ff;
                            overrun_o <= ~rx.ready;
                        end else begin
                            frame_err_o <= 1'b1;
                        end
                    end
                end
                default: begin
                    rx_st_ff <= DASP_RX_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- dasp_serial_peer.sv
// Behavioural far-end serial device serving both ports
`timescale 1ns/1ps
`default_nettype none
module dasp_serial_peer (
    input wire logic clk_sys_i,
    input wire logic [1:0] line_i,
    input wire logic [33:0] div_i,
    output logic [1:0] line_o,
    output logic [1:0] got_valid_o,
    output logic [17:0] got_data_o
);
    // ==========================================================
    // Sender: drives the device's receive lines, idle high
    initial line_o = 2'b11;
    task automatic send(input int p, input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        @(posedge clk_sys_i);
        for (int i = 0; i < 10; i++) begin
            line_o[p] <= frame[i];
            repeat (div_i[17*p +: 17]) @(posedge clk_sys_i);
        end
        if (!stop) begin
            line_o[p] <= 1'b1;
        end
    endtask
    // ==========================================================
    // Receiver: mid-bit sampling, reports stop level with the byte
    for (genvar p = 0; p < 2; p++) begin : g_rx
        initial begin
            logic [7:0] b;
            int d;
            got_valid_o[p] = 1'b0;
            got_data_o[9*p +: 9] = 9'h000;
            forever begin
                @(negedge line_i[p]);
                d = div_i[17*p +: 17];
                repeat (d / 2) @(posedge clk_sys_i);
                for (int i = 0; i < 8; i++) begin
                    repeat (d) @(posedge clk_sys_i);
                    b[i] = line_i[p];
                end
                repeat (d) @(posedge clk_sys_i);
                got_data_o[9*p +: 9] <= {line_i[p], b};
                got_valid_o[p] <= 1'b1;
                @(posedge clk_sys_i);
                got_valid_o[p] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- dasp_stream_if.sv
// Byte stream carrier between the serial engine and its receive FIFO
`timescale 1ns/1ps
`default_nettype none
interface dasp_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- dasp_top.sv
// Top of the dual asynchronous serial port block
`timescale 1ns/1ps
`default_nettype none
module dasp_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic master_reset_n_i,
    input wire logic [16:0] baud_div_zero_i,
    input wire logic [16:0] baud_div_one_i,
    input wire logic app_start_i,
    input wire logic port_zero_receive_line_i,
    output logic port_zero_transmit_line_o,
    input wire logic port_one_receive_line_i,
    output logic port_one_transmit_line_o,
    input wire logic [1:0] tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic [1:0] tx_ready_o,
    input wire logic [1:0] rx_ready_i,
    output logic [1:0] rx_valid_o,
    output logic [15:0] rx_data_o,
    input wire logic [1:0] load_ready_i,
    output logic load_valid_o,
    output logic [7:0] load_data_o,
    output logic port_zero_app_o,
    output logic [1:0] frame_err_o,
    output logic [1:0] overrun_o
);
    // ==========================================================
    // Module reset from the pin, filtered by the minimum low time
    logic [6:0] rst_cnt_ff;
    logic mrst_ff;
    logic blk_rst;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rst_cnt_ff <= '0;
            mrst_ff <= 1'b0;
        end else if (master_reset_n_i) begin
            rst_cnt_ff <= '0;
            mrst_ff <= 1'b0;
        end else if (rst_cnt_ff == dasp_pkg::RST_CYC_W) begin
            mrst_ff <= 1'b1;
        end else begin
            rst_cnt_ff <= rst_cnt_ff + 7'h01;
        end
    end

    // Pulses shorter than the minimum low time are ignored; held reset is registered in mrst_ff, so it asserts and releases on clock edges
    assign blk_rst = rst_i | mrst_ff;

    // ==========================================================
    // Port zero ownership
    dasp_pkg::dasp_own_e own_ff;

    always_ff @(posedge clk_sys_i or posedge blk_rst) begin
        if (blk_rst) begin
            own_ff <= dasp_pkg::DASP_OWN_LOADER;
        end else if (app_start_i) begin
            own_ff <= dasp_pkg::DASP_OWN_APP;
        end
    end

    // ==========================================================
    // Baud divisors, clamped to the supported range
    logic [16:0] div_ff [2];
    logic [16:0] div_req [2];
    logic [1:0] rx_lines;
    logic [1:0] tx_lines;
    logic [1:0] tx_valid_q;
    logic [1:0] fifo_ready;
    logic [1:0] fifo_valid;
    logic [15:0] fifo_data;
    logic [1:0] fe;
    logic [1:0] ov;
    logic [1:0] txr;

    assign div_req[0] = baud_div_zero_i;
    assign div_req[1] = baud_div_one_i;
    assign rx_lines = {port_one_receive_line_i, port_zero_receive_line_i};

    // Taken only where valid meets ready; ready stays low while the loader owns port zero
    assign tx_valid_q = tx_valid_i & tx_ready_o;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_port
            dasp_stream_if rxs ();

            always_ff @(posedge clk_sys_i or posedge blk_rst) begin
                if (blk_rst) begin
                    div_ff[g] <= dasp_pkg::DIV_RST;
                end else if (div_req[g] < 17'(dasp_pkg::DIV_MIN)) begin
                    div_ff[g] <= 17'(dasp_pkg::DIV_MIN);
                end else if (div_req[g] > 17'(dasp_pkg::DIV_MAX)) begin
                    div_ff[g] <= 17'(dasp_pkg::DIV_MAX);
                end else begin
                    div_ff[g] <= div_req[g];
                end
            end

            // Each port has its own engines and line pair
            dasp_port u_port (
                .clk_sys_i(clk_sys_i),
                .rst_i(blk_rst),
                .div_i(div_ff[g]),
                .rx_line_i(rx_lines[g]),
                .tx_line_o(tx_lines[g]),
                .tx_valid_i(tx_valid_q[g]),
                .tx_data_i(tx_data_i[g*8 +: 8]),
                .tx_ready_o(txr[g]),
                .frame_err_o(fe[g]),
                .overrun_o(ov[g]),
                .rx(rxs.src)
            );

            dasp_fifo #(
                .WIDTH(8),
                .DEPTH(dasp_pkg::FIFO_DEPTH)
            ) u_fifo (
                .clk_sys_i(clk_sys_i),
                .rst_i(blk_rst),
                .flush_i(1'b0),
                .wr(rxs.snk),
                .rd_valid_o(fifo_valid[g]),
                .rd_data_o(fifo_data[g*8 +: 8]),
                .rd_ready_i(fifo_ready[g]),
                .full_o()
            );
        end
    endgenerate

    // ==========================================================
    // Route port zero data: loader first, application later
    // Only port zero feeds the loader; port one cannot reach it
    logic take0;
    logic take1;
    logic load_path;

    assign load_path = (own_ff == dasp_pkg::DASP_OWN_LOADER);
    // Output stage accepts when empty or being consumed
    assign take0 = fifo_valid[0] & (load_path ?
        (~load_valid_o | load_ready_i[0]) : (~rx_valid_o[0] | rx_ready_i[0]));
    assign take1 = fifo_valid[1] & (~rx_valid_o[1] | rx_ready_i[1]);
    assign fifo_ready = {take1, take0};

    always_ff @(posedge clk_sys_i or posedge blk_rst) begin
        if (blk_rst) begin
            load_valid_o <= 1'b0;
            load_data_o <= '0;
            rx_valid_o <= '0;
            rx_data_o <= '0;
        end else begin
            if (load_ready_i[0] | ~load_path) begin
                load_valid_o <= 1'b0;
            end
            if (rx_ready_i[0]) begin
                rx_valid_o[0] <= 1'b0;
            end
            if (rx_ready_i[1]) begin
                rx_valid_o[1] <= 1'b0;
            end
            if (take0 & load_path) begin
                load_valid_o <= 1'b1;
                load_data_o <= fifo_data[7:0];
            end
            if (take0 & ~load_path) begin
                rx_valid_o[0] <= 1'b1;
                rx_data_o[7:0] <= fifo_data[7:0];
            end
            if (take1) begin
                rx_valid_o[1] <= 1'b1;
                rx_data_o[15:8] <= fifo_data[15:8];
            end
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge clk_sys_i or posedge blk_rst) begin
        if (blk_rst) begin
            port_zero_transmit_line_o <= dasp_pkg::IDLE_LVL;
            port_one_transmit_line_o <= dasp_pkg::IDLE_LVL;
            tx_ready_o <= '0;
            port_zero_app_o <= 1'b0;
            frame_err_o <= '0;
            overrun_o <= '0;
        end else begin
            port_zero_transmit_line_o <= tx_lines[0];
            port_one_transmit_line_o <= tx_lines[1];
            tx_ready_o <= {txr[1], txr[0] & ~load_path} & ~tx_valid_q;
            port_zero_app_o <= ~load_path;
            frame_err_o <= fe;
            overrun_o <= ov;
        end
    end
endmodule
`default_nettype wire

//--- test_dual_async_serial_ports.sv
// Self-checking bench for the dual asynchronous serial ports
`timescale 1ns/1ps
`default_nettype none
module test_dual_async_serial_ports;
    // ==========================================================
    // Wiring
    logic clk_sys_i, rst_i, master_reset_n_i, app_start_i, load_valid, zero_app;
    logic [16:0] baud_div_zero, baud_div_one;
    logic [1:0] tx_valid, tx_ready, rx_ready, rx_valid, load_ready, frame_err, overrun;
    logic [1:0] line_to_dut, line_from_dut, got_valid;
    logic [15:0] tx_data, rx_data;
    logic [17:0] got_data;
    logic [7:0] load_data;
    logic [31:0] rng;
    logic [7:0] exp_rx[3][$];
    logic [8:0] exp_tx[2][$];
    int n_errors, samples_checked, n_ferr, n_ovr;
    dasp_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .master_reset_n_i(master_reset_n_i),
        .baud_div_zero_i(baud_div_zero), .baud_div_one_i(baud_div_one), .app_start_i(app_start_i),
        .port_zero_receive_line_i(line_to_dut[0]), .port_zero_transmit_line_o(line_from_dut[0]),
        .port_one_receive_line_i(line_to_dut[1]), .port_one_transmit_line_o(line_from_dut[1]),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_ready_i(rx_ready),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .load_ready_i(load_ready),
        .load_valid_o(load_valid), .load_data_o(load_data), .port_zero_app_o(zero_app),
        .frame_err_o(frame_err), .overrun_o(overrun));
    dasp_serial_peer peer (.clk_sys_i(clk_sys_i), .line_i(line_from_dut),
        .div_i({baud_div_one, baud_div_zero}), .line_o(line_to_dut), .got_valid_o(got_valid),
        .got_data_o(got_data));
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [8:0] pop_rx(input int i);
        return exp_rx[i].size() != 0 ? {1'b0, exp_rx[i].pop_front()} : 9'hxxx;
    endfunction
    function automatic logic [8:0] pop_tx(input int i);
        return exp_tx[i].size() != 0 ? exp_tx[i].pop_front() : 9'hxxx;
    endfunction
    task automatic check(input logic [8:0] exp, input logic [8:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hold valid until the edge that sees ready; ready lags, so drop it right there
    task automatic send_tx(input int p, input logic [7:0] b);
        @(posedge clk_sys_i);
        tx_valid[p] <= 1'b1;
        tx_data[8*p +: 8] <= b;
        exp_tx[p].push_back({1'b1, b});
        for (int w = 0; w < 2000; w++) begin
            @(posedge clk_sys_i);
            if (tx_ready[p] === 1'b1) break;
        end
        tx_valid[p] <= 1'b0;
    endtask
    task automatic duplex(input int p);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            rng = xorshift(rng);
            b = rng[7:0];
            send_tx(p, b);
        end
    endtask
    // FIFO plus output register hold 33 bytes; later ones are dropped
    task automatic feed(input int p, input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            rng = xorshift(rng);
            b = rng[7:0];
            if (i < 33) exp_rx[p].push_back(b);
            peer.send(p, b, 1'b1);
        end
    endtask
    task automatic wait_drain(input string name);
        int w;
        for (w = 0; w < 20000; w++) begin
            @(posedge clk_sys_i);
            if (exp_rx[0].size() + exp_rx[1].size() + exp_rx[2].size()
                + exp_tx[0].size() + exp_tx[1].size() == 0) break;
        end
        @(negedge clk_sys_i);
        check(9'h000, 9'(w == 20000));
        $display("test %s done", name);
    endtask
    task automatic pulse_reset(input int n);
        @(posedge clk_sys_i);
        master_reset_n_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        master_reset_n_i <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
    endtask
    // ==========================================================
    // Result monitor
    always @(negedge clk_sys_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rx_valid[p] === 1'b1 && rx_ready[p] === 1'b1) check(pop_rx(p), {1'b0, rx_data[8*p +: 8]});
            if (got_valid[p] === 1'b1) check(pop_tx(p), got_data[9*p +: 9]);
        end
        if (load_valid === 1'b1 && load_ready[0] === 1'b1) check(pop_rx(2), {1'b0, load_data});
        n_ferr += $countones(frame_err);
        n_ovr += $countones(overrun);
    end
    // ==========================================================
    // Scenarios
    initial begin
        rst_i = 1'b1;
        master_reset_n_i = 1'b1;
        app_start_i = 1'b0;
        baud_div_zero = 17'h00029;
        baud_div_one = 17'h00032;
        tx_valid = 2'b00;
        tx_data = 16'h0000;
        rx_ready = 2'b11;
        load_ready = 2'b11;
        rng = 32'h000041e4;
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        check(9'h003, {7'h00, line_from_dut});
        check(9'h000, {7'h00, zero_app, tx_ready[0]});
        exp_rx[2].push_back(8'ha5);
        exp_rx[2].push_back(8'h3c);
        peer.send(0, 8'ha5, 1'b1);
        peer.send(0, 8'h3c, 1'b1);
        wait_drain("loader");
        @(posedge clk_sys_i);
        app_start_i <= 1'b1;
        @(posedge clk_sys_i);
        app_start_i <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        check(9'h003, {7'h00, zero_app, tx_ready[0]});
        fork
            duplex(0);
            duplex(1);
            feed(0, 4);
            feed(1, 4);
        join
        wait_drain("duplex");
        peer.send(1, 8'h55, 1'b0);
        exp_rx[1].push_back(8'h96);
        peer.send(1, 8'h96, 1'b1);
        wait_drain("frame_error");
        check(9'h001, 9'(n_ferr));
        @(posedge clk_sys_i);
        rx_ready[1] <= 1'b0;
        feed(1, 34);
        repeat (5) @(posedge clk_sys_i);
        check(9'h001, 9'(n_ovr));
        rx_ready[1] <= 1'b1;
        wait_drain("overrun");
        pulse_reset(20);
        check(9'h001, {8'h00, zero_app});
        pulse_reset(60);
        check(9'h000, {7'h00, zero_app, tx_ready[0]});
        exp_rx[2].push_back(8'h81);
        peer.send(0, 8'h81, 1'b1);
        wait_drain("master_reset");
        print_verdict();
    end
    // Whole run needs some 22000 cycles; allow more than twice that
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_errors++;
        $display("FAIL t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
